// ---- sif_pkg.sv ----
// Purpose: constants and types of the stepper indexer and fault control
// Assumes: hclk at 25 MHz
// Notes:   register offsets are byte addresses on the ahb-lite slave
package sif_pkg;
    // ==================================================
    // timing
    localparam int unsigned CLK_MHZ     = 25;
    localparam int unsigned OC_TIME_US  = 800;
    localparam int unsigned OC_CYCLES   = OC_TIME_US * CLK_MHZ;
    localparam int unsigned OC_CNT_W    = 15;
    // ==================================================
    // register map
    localparam logic [7:0]  ADDR_DECAY  = 8'h00;
    localparam logic [7:0]  ADDR_OFF    = 8'h04;
    localparam logic [7:0]  ADDR_BLANK  = 8'h08;
    localparam logic [7:0]  ADDR_FAST   = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS = 8'h10;
    localparam logic [15:0] OFF_RST     = 16'h00c7;
    localparam logic [15:0] BLANK_RST   = 16'h0018;
    localparam logic [15:0] FAST_RST    = 16'h0031;
    // ==================================================
    // indexer
    localparam logic [4:0] HOME_IDX   = 5'h04;
    localparam logic [4:0] FULL_STEP  = 5'h08;
    localparam logic [4:0] QTR_IDX    = 5'h08;
    localparam logic [4:0] HALF_IDX   = 5'h10;
    localparam logic [4:0] THREEQ_IDX = 5'h18;
    localparam logic [3:0] QTR_PTS    = 4'h8;
    localparam logic [6:0] SINE_TAB [0:8] = '{
        7'h00, 7'h14, 7'h26, 7'h38, 7'h47, 7'h53, 7'h5c, 7'h62, 7'h64};
    // ==================================================
    // bridge drive modes
    localparam logic [1:0] BR_OFF   = 2'h0;
    localparam logic [1:0] BR_DRIVE = 2'h1;
    localparam logic [1:0] BR_SLOW  = 2'h2;
    localparam logic [1:0] BR_FAST  = 2'h3;
    typedef enum logic [1:0] {
        DEC_SLOW  = 2'h0,
        DEC_FAST  = 2'h1,
        DEC_MIXED = 2'h2
    } sif_decay_type;
    typedef enum logic [1:0] {
        CH_BLANK = 2'b00,
        CH_RUN   = 2'b01,
        CH_FAST  = 2'b11,
        CH_SLOW  = 2'b10
    } sif_chop_type;
endpackage

// ---- sif_stepper_ctrl.sv ----
// Purpose: step indexer, fixed off-time chopper and fault shutdown
// Assumes: pins synchronous to hclk; fault detectors external
// Notes:   ahb-lite slave with zero wait states
//
// What this block does
// - overcurrent turns that bridge fully off for about 800 us
// - enable high-then-low or power cycling ends overcurrent shutdown early
// - overcurrent detection covers current in both directions
// - overcurrent input is separate from the chopping trip comparator
// - an overcurrent event also returns the phase index home
// - overtemperature disables drivers, homes index, resumes when it clears
// - either supply below lockout disables everything and homes index
// - restart only when both supplies are above lockout again
// - clear input low holds index home and bridges off
// - clear input low ignores step pulses
// - enable low drives bridges, high turns them off
// - with bridges disabled, index still follows step and direction
// - sleep low disables bridges, charge pump and internal activity
// - during sleep step, direction, clear and overcurrent inputs are ignored; lockout and overtemperature still home index
// - slow, fast and mixed decay with fixed off-time chopping
// - drive until trip, decay for fixed period, then drive again
// - blanking after drive start ignores the trip comparator
// - step rising edge moves index forward if direction high, else back
// - home is 45 degrees; home flag low only there
// - two-bit resolution selects full, half, quarter or eighth step
// - fast or mixed decay only while target current falls
`timescale 1ns/1ps
module sif_stepper_ctrl
    import sif_pkg::*;
#(
    parameter int unsigned OC_HOLD_CYCLES = OC_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    input  wire logic        step_in,
    input  wire logic        dir_in,
    input  wire logic        indexer_clear_low,
    input  wire logic        bridge_output_on_low,
    input  wire logic        low_power_request_low,
    input  wire logic        resolution_select_hi,
    input  wire logic        resolution_select_lo,
    input  wire logic        trip_a,
    input  wire logic        trip_b,
    input  wire logic        overcurrent_det_a,
    input  wire logic        overcurrent_det_b,
    input  wire logic        overtemp_det,
    input  wire logic        motor_supply_ok,
    input  wire logic        logic_supply_ok,
    output logic             home_position_flag_low,
    output logic       [6:0] target_mag_a,
    output logic             target_neg_a,
    output logic       [6:0] target_mag_b,
    output logic             target_neg_b,
    output logic       [1:0] bridge_mode_a,
    output logic       [1:0] bridge_mode_b,
    output logic             charge_pump_on,
    output logic             overcurrent_shutdown_a,
    output logic             overcurrent_shutdown_b,
    output logic             overtemperature_shutdown,
    output logic             low_supply_lockout
);
    localparam logic [OC_CNT_W-1:0] OC_LAST =
        OC_CNT_W'(OC_HOLD_CYCLES - 1);

    // one clock domain, so every check shares these
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==================================================
    // ahb-lite register slave
    logic [7:0]    wr_addr_q;
    logic          wr_pend_q;
    logic [31:0]   hrdata_q;
    logic [31:0]   rd_mux;
    sif_decay_type decay_q;
    logic [15:0]   off_len_q;
    logic [15:0]   blank_len_q;
    logic [15:0]   fast_len_q;
    logic [4:0]    idx_q;
    logic [1:0]    oc_q;
    logic          hot_q;
    logic          lock_q;
    logic          home_q;
    logic          addr_ok;

    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_comb begin
        rd_mux = 32'h0;
        if (haddr[7:0] == ADDR_DECAY) begin
            rd_mux = {30'h0, decay_q};
        end else if (haddr[7:0] == ADDR_OFF) begin
            rd_mux = {16'h0, off_len_q};
        end else if (haddr[7:0] == ADDR_BLANK) begin
            rd_mux = {16'h0, blank_len_q};
        end else if (haddr[7:0] == ADDR_FAST) begin
            rd_mux = {16'h0, fast_len_q};
        end else if (haddr[7:0] == ADDR_STATUS) begin
            rd_mux = {22'h0, lock_q, hot_q, oc_q, home_q, idx_q};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h0;
            hrdata_q  <= 32'h0;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // unknown decay codes fall back to slow decay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decay_q     <= DEC_SLOW;
            off_len_q   <= OFF_RST;
            blank_len_q <= BLANK_RST;
            fast_len_q  <= FAST_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == ADDR_DECAY) begin
                decay_q <= (hwdata[1:0] == DEC_FAST) ? DEC_FAST :
                           (hwdata[1:0] == DEC_MIXED) ? DEC_MIXED :
                           DEC_SLOW;
            end else if (wr_addr_q == ADDR_OFF) begin
                off_len_q <= hwdata[15:0];
            end else if (wr_addr_q == ADDR_BLANK) begin
                blank_len_q <= hwdata[15:0];
            end else if (wr_addr_q == ADDR_FAST) begin
                fast_len_q <= hwdata[15:0];
            end
        end
    end

    // ==================================================
    // supply, thermal and sleep state
    logic awake;
    logic lock_now;
    logic step_q;
    logic step_rise;
    logic home_force;
    logic [4:0] stride;
    logic [1:0] oc_det;
    logic [1:0] trip;

    assign awake     = low_power_request_low;
    assign lock_now  = !motor_supply_ok || !logic_supply_ok;
    assign step_rise = step_in && !step_q;
    assign oc_det    = {overcurrent_det_b, overcurrent_det_a};
    assign trip      = {trip_b, trip_a};
    assign stride    = FULL_STEP >>
        {resolution_select_hi, resolution_select_lo};
    assign home_force = lock_now || overtemp_det ||
        (awake && (!indexer_clear_low || (|oc_det)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hot_q   <= 1'b0;
            lock_q  <= 1'b0;
            step_q  <= 1'b0;
            charge_pump_on <= 1'b0;
        end else begin
            hot_q  <= overtemp_det;
            lock_q <= lock_now;
            step_q <= step_in;
            charge_pump_on <= awake && !lock_now;
        end
    end

    // ==================================================
    // indexer
    // sleep freezes the index, so steps during sleep are lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q  <= HOME_IDX;
            home_q <= 1'b1;
        end else begin
            if (home_force) begin
                idx_q <= HOME_IDX;
            end else if (awake && step_rise) begin
                idx_q <= dir_in ? idx_q + stride
                                : idx_q - stride;
            end
            home_q <= home_force ||
                ((awake && step_rise) ? 1'b0 : (idx_q == HOME_IDX));
        end
    end
    // home flag lags a step onto home by one cycle; a step away from home shows at once
    assign home_position_flag_low = !(home_q && (idx_q == HOME_IDX));

    function automatic logic [6:0] mag_of(input logic [4:0] i,
                                          input logic sine);
        logic [3:0] q;
        logic [3:0] p;
        q = {1'b0, i[2:0]};
        p = (i[3] ^ sine) ? q : QTR_PTS - q;
        return SINE_TAB[p];
    endfunction

    // ==================================================
    // overcurrent shutdown and chopper, one per bridge
    logic [1:0]  en_seen_q;
    logic [1:0]  falling_q;
    logic [1:0]  bridge_ok;
    logic [6:0]  mag_q   [2];
    logic [6:0]  mag_d   [2];
    logic [1:0]  neg_q;
    logic [1:0]  neg_d;
    logic [1:0]  mode_q  [2];
    logic [15:0] cnt_q   [2];
    logic [OC_CNT_W-1:0] oc_cnt_q [2];
    sif_chop_type chop_q [2];

    assign mag_d[0] = mag_of(idx_q, 1'b0);
    assign mag_d[1] = mag_of(idx_q, 1'b1);
    assign neg_d[0] = (idx_q > QTR_IDX) && (idx_q < THREEQ_IDX);
    assign neg_d[1] = idx_q > HALF_IDX;

    for (genvar b = 0; b < 2; b++) begin : g_br
        assign bridge_ok[b] = awake && !bridge_output_on_low &&
            indexer_clear_low && !oc_q[b] && !oc_det[b] &&
            !overtemp_det && !lock_now;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                oc_q[b]      <= 1'b0;
                oc_cnt_q[b]  <= '0;
                en_seen_q[b] <= 1'b0;
            end else if (lock_now) begin
                oc_q[b] <= 1'b0;
            end else if (awake && oc_det[b]) begin
                oc_q[b]      <= 1'b1;
                oc_cnt_q[b]  <= '0;
                en_seen_q[b] <= 1'b0;
            end else if (awake && oc_q[b]) begin
                if (oc_cnt_q[b] == OC_LAST ||
                    (en_seen_q[b] && !bridge_output_on_low)) begin
                    oc_q[b] <= 1'b0;
                end
                oc_cnt_q[b] <= oc_cnt_q[b] + 1'b1;
                if (bridge_output_on_low) begin
                    en_seen_q[b] <= 1'b1;
                end
            end
        end

        // current target and whether it is falling
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                mag_q[b]     <= '0;
                neg_q[b]     <= 1'b0;
                falling_q[b] <= 1'b0;
            end else begin
                mag_q[b] <= mag_d[b];
                neg_q[b] <= neg_d[b];
                if (mag_d[b] != mag_q[b]) begin
                    falling_q[b] <= mag_d[b] < mag_q[b];
                end
            end
        end

        // trip is only looked at in run, so blanking masks it
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                chop_q[b] <= CH_BLANK;
                cnt_q[b]  <= '0;
                mode_q[b] <= BR_OFF;
            end else if (!bridge_ok[b]) begin
                chop_q[b] <= CH_BLANK;
                cnt_q[b]  <= '0;
                mode_q[b] <= BR_OFF;
            end else begin
                case (chop_q[b])
                    CH_BLANK: begin
                        mode_q[b] <= BR_DRIVE;
                        cnt_q[b]  <= cnt_q[b] + 1'b1;
                        if (cnt_q[b] == blank_len_q) begin
                            chop_q[b] <= CH_RUN;
                            cnt_q[b]  <= '0;
                        end
                    end
                    CH_RUN: begin
                        mode_q[b] <= BR_DRIVE;
                        cnt_q[b]  <= '0;
                        if (trip[b]) begin
                            if (decay_q == DEC_SLOW || !falling_q[b]) begin
                                chop_q[b] <= CH_SLOW;
                                mode_q[b] <= BR_SLOW;
                            end else begin
                                chop_q[b] <= CH_FAST;
                                mode_q[b] <= BR_FAST;
                            end
                        end
                    end
                    CH_FAST: begin
                        cnt_q[b] <= cnt_q[b] + 1'b1;
                        if (cnt_q[b] == off_len_q) begin
                            chop_q[b] <= CH_BLANK;
                            mode_q[b] <= BR_DRIVE;
                            cnt_q[b]  <= '0;
                        end else if (decay_q == DEC_MIXED &&
                                     cnt_q[b] == fast_len_q) begin
                            chop_q[b] <= CH_SLOW;
                            mode_q[b] <= BR_SLOW;
                        end
                    end
                    default: begin
                        cnt_q[b] <= cnt_q[b] + 1'b1;
                        if (cnt_q[b] == off_len_q) begin
                            chop_q[b] <= CH_BLANK;
                            mode_q[b] <= BR_DRIVE;
                            cnt_q[b]  <= '0;
                        end
                    end
                endcase
            end
        end

        // ==================================================
        // checks per bridge
        oc_hold_a: assert property ($fell(oc_q[b]) |->
            $past(oc_cnt_q[b]) == OC_LAST || $past(en_seen_q[b]) ||
            $past(lock_now))
            else $error("overcurrent shutdown ended early");
        oc_off_a: assert property (awake && oc_det[b] && !lock_now |=>
            oc_q[b] && mode_q[b] == BR_OFF && idx_q == HOME_IDX)
            else $error("overcurrent did not shut down and home");
        blank_mask_a: assert property (bridge_ok[b] &&
            chop_q[b] == CH_BLANK && cnt_q[b] != blank_len_q |=>
            chop_q[b] == CH_BLANK)
            else $error("trip acted during blanking");
        rise_slow_a: assert property (bridge_ok[b] &&
            chop_q[b] == CH_RUN && trip[b] && !falling_q[b]
            |=> chop_q[b] == CH_SLOW ##0 mode_q[b] == BR_SLOW)
            else $error("rising current did not use slow decay");
        enable_off_a: assert property (bridge_output_on_low |=>
            mode_q[b] == BR_OFF)
            else $error("bridge driven while disabled");
        sleep_off_a: assert property (!low_power_request_low |=>
            mode_q[b] == BR_OFF && !charge_pump_on)
            else $error("sleep left bridge or pump on");
        mixed_cv: cover property (chop_q[b] == CH_FAST ##1
            chop_q[b] == CH_SLOW);
    end

    assign target_mag_a  = mag_q[0];
    assign target_mag_b  = mag_q[1];
    assign target_neg_a  = neg_q[0];
    assign target_neg_b  = neg_q[1];
    assign bridge_mode_a = mode_q[0];
    assign bridge_mode_b = mode_q[1];
    assign overcurrent_shutdown_a   = oc_q[0];
    assign overcurrent_shutdown_b   = oc_q[1];
    assign overtemperature_shutdown = hot_q;
    assign low_supply_lockout       = lock_q;

    // ==================================================
    // checks on the indexer
    step_move_a: assert property (awake && step_rise && !home_force |=>
        idx_q == $past(dir_in ? idx_q + stride : idx_q - stride))
        else $error("step moved index wrongly");
    clear_home_a: assert property (awake && !indexer_clear_low |=>
        idx_q == HOME_IDX && home_position_flag_low == 1'b0)
        else $error("clear did not hold index home");
    hot_home_a: assert property (overtemp_det |=>
        idx_q == HOME_IDX && hot_q)
        else $error("overtemperature did not home index");
    lock_home_a: assert property (lock_now |=>
        idx_q == HOME_IDX && low_supply_lockout)
        else $error("lockout did not home index");
    sleep_hold_a: assert property (!awake && !lock_now &&
        !overtemp_det |=> $stable(idx_q))
        else $error("index moved during sleep");
    home_flag_a: assert property (idx_q != HOME_IDX ||
        $past(idx_q) == HOME_IDX |->
        home_position_flag_low == (idx_q != HOME_IDX))
        else $error("home flag wrong for index");
    step_cv: cover property (awake && step_rise && !home_force);
    oc_cv: cover property ($fell(overcurrent_shutdown_a));
    full_cv: cover property (awake && step_rise &&
        stride == FULL_STEP);
endmodule

// ---- sif_motion_model.sv ----
// Purpose: motion controller model issuing step and direction
// Assumes: bench calls pulse with a hold time of one cycle or more
// Notes:   varied hold times stand for prompt and slow hosts
`timescale 1ns/1ps
module sif_motion_model (
    input  wire logic hclk,
    output logic      step_in,
    output logic      dir_in
);
    // ==========================================
    // step pulses
    initial begin
        step_in = 1'b0;
        dir_in  = 1'b1;
    end
    // direction settles a cycle ahead so the edge never races it
    task automatic pulse(input logic fwd, input int hold);
        @(posedge hclk);
        dir_in <= fwd;
        @(posedge hclk);
        step_in <= 1'b1;
        repeat (hold) @(posedge hclk);
        step_in <= 1'b0;
        repeat (hold) @(posedge hclk);
    endtask
endmodule

// ---- stepper_indexer_fault_control_test.sv ----
// Purpose: self-checking bench of the stepper indexer
// Assumes: overcurrent hold shortened to 50 cycles
// Notes:   seed fixed, so runs repeat
`timescale 1ns/1ps
module stepper_indexer_fault_control_test import sif_pkg::*; ;
    // ==========================================
    // signals
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, bridge_mode_a, bridge_mode_b, r, ex;
    logic [2:0]  hsize;
    logic        step_in, dir_in, indexer_clear_low, bridge_output_on_low;
    logic        low_power_request_low, resolution_select_hi, f;
    logic        resolution_select_lo, trip_a, trip_b, overcurrent_det_a;
    logic        overcurrent_det_b, overtemp_det, motor_supply_ok;
    logic        logic_supply_ok, home_position_flag_low, target_neg_a;
    logic        target_neg_b, charge_pump_on, overcurrent_shutdown_a;
    logic        overcurrent_shutdown_b, overtemperature_shutdown;
    logic        low_supply_lockout;
    logic [6:0]  target_mag_a, target_mag_b;
    logic [4:0]  idx;
    int          error_cnt, checks, cyc, seed, n;
    logic [6:0]  pct [0:8] = '{7'h00, 7'h14, 7'h26, 7'h38, 7'h47,
                              7'h53, 7'h5c, 7'h62, 7'h64};
    assign hready = hreadyout;
    sif_stepper_ctrl #(.OC_HOLD_CYCLES(50)) i_dut (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .step_in, .dir_in, .indexer_clear_low,
        .bridge_output_on_low, .low_power_request_low, .resolution_select_hi,
        .resolution_select_lo, .trip_a, .trip_b, .overcurrent_det_a,
        .overcurrent_det_b, .overtemp_det, .motor_supply_ok,
        .logic_supply_ok, .home_position_flag_low, .target_mag_a,
        .target_neg_a, .target_mag_b, .target_neg_b, .bridge_mode_a,
        .bridge_mode_b, .charge_pump_on, .overcurrent_shutdown_a,
        .overcurrent_shutdown_b, .overtemperature_shutdown,
        .low_supply_lockout);
    sif_motion_model i_ctl (.hclk, .step_in, .dir_in);
    // ==========================================
    // clock, timeout, helpers
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    // {sign, magnitude} of the sine target, zero carries no sign
    function automatic logic [7:0] snv(input logic [4:0] i);
        logic [3:0] s;
        s = i[3:0];
        snv = {i > 5'h10, pct[(s > 4'h8) ? 4'h0 - s : s]};
    endfunction
    function automatic logic [4:0] nxt(input logic [4:0] i, input logic d,
                                      input logic [1:0] m);
        nxt = d ? i + (5'h08 >> m) : i - (5'h08 >> m);
    endfunction
    task automatic chk_pos(input logic [4:0] i);
        logic [7:0] va;
        logic [7:0] vb;
        va = snv(i + 5'h08);
        vb = snv(i);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[4:0], i);
        check(hresp, 1'b0);
        check(home_position_flag_low, i != HOME_IDX);
        check({target_neg_a & |va[6:0], target_mag_a}, va);
        check({target_neg_b & |vb[6:0], target_mag_b}, vb);
    endtask
    task automatic stp(input logic d, input logic [1:0] m);
        {resolution_select_hi, resolution_select_lo} <= m;
        i_ctl.pulse(d, 1 + $unsigned($random(seed)) % 3);
        tick(2);
    endtask
    task automatic fault_off;
        check(bridge_mode_a, BR_OFF);
        check(bridge_mode_b, BR_OFF);
    endtask
    // ==========================================
    // main sequence
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, trip_a, trip_b} = '0;
        {overcurrent_det_a, overcurrent_det_b, overtemp_det} = '0;
        {resolution_select_hi, resolution_select_lo} = 2'h3;
        {indexer_clear_low, low_power_request_low} = 2'h3;
        {motor_supply_ok, logic_supply_ok} = 2'h3;
        bridge_output_on_low = 1'b0;
        hsize = 3'h2;
        hresetn = 1'b0;
        {error_cnt, checks, cyc} = '0;
        seed = 15;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        idx = HOME_IDX;
        chk_pos(idx);
        ahb(1'b0, ADDR_OFF, 32'h0);
        check(rd, {16'h0, OFF_RST});
        ahb(1'b0, ADDR_BLANK, 32'h0);
        check(rd, {16'h0, BLANK_RST});
        ahb(1'b0, ADDR_FAST, 32'h0);
        check(rd, {16'h0, FAST_RST});
        ahb(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, ADDR_OFF, 32'h9);
        ahb(1'b1, ADDR_BLANK, 32'h3);
        ahb(1'b1, ADDR_FAST, 32'h3);
        ahb(1'b0, ADDR_OFF, 32'h0);
        check(rd, 32'h9);
        for (int k = 0; k < 30; k++) begin
            f = 1'($random(seed));
            r = 2'($random(seed));
            bridge_output_on_low <= 1'($random(seed));
            stp(f, r);
            idx = nxt(idx, f, r);
            if (bridge_output_on_low) check(bridge_mode_a, BR_OFF);
            chk_pos(idx);
        end
        bridge_output_on_low <= 1'b0;
        indexer_clear_low <= 1'b0;
        tick(2);
        fault_off();
        stp(1'b1, 2'h0);
        indexer_clear_low <= 1'b1;
        tick(2);
        idx = HOME_IDX;
        chk_pos(idx);
        for (int k = 0; k < 6; k++) begin
            f = ~k[0];
            ex = (f && k > 1) ? BR_FAST : BR_SLOW;
            trip_a <= 1'b0;
            ahb(1'b1, ADDR_DECAY, k / 2);
            tick(20);
            stp(f, 2'h3);
            trip_a <= 1'b1;
            n = 0;
            while (bridge_mode_a === BR_DRIVE && n < 50) begin
                tick(1);
                n++;
            end
            check(bridge_mode_a, ex);
            if (k == 4) begin
                n = 0;
                while (bridge_mode_a === BR_FAST && n < 50) begin
                    tick(1);
                    n++;
                end
                check(n, 4);
                check(bridge_mode_a, BR_SLOW);
            end
            if (k == 0) begin
                n = 0;
                while (bridge_mode_a === BR_SLOW && n < 50) begin
                    tick(1);
                    n++;
                end
                check(n, 10);
                n = 0;
                while (bridge_mode_a === BR_DRIVE && n < 50) begin
                    tick(1);
                    n++;
                end
                check(n, 5);
            end
        end
        trip_a <= 1'b0;
        stp(1'b1, 2'h2);
        low_power_request_low <= 1'b0;
        tick(2);
        check(charge_pump_on, 1'b0);
        check(bridge_mode_a, BR_OFF);
        stp(1'b1, 2'h0);
        low_power_request_low <= 1'b1;
        tick(2);
        idx = 5'h06;
        chk_pos(idx);
        for (int k = 0; k < 4; k++) begin
            stp(1'b1, 2'h1);
            {overcurrent_det_b, overcurrent_det_a} <= k[0] ? 2'h2 : 2'h1;
            tick(1);
            {overcurrent_det_b, overcurrent_det_a} <= 2'h0;
            tick(2);
            check({overcurrent_shutdown_b, overcurrent_shutdown_a},
                  k[0] ? 2'h2 : 2'h1);
            check(k[0] ? bridge_mode_b : bridge_mode_a, BR_OFF);
            check(k[0] ? bridge_mode_a : bridge_mode_b, BR_DRIVE);
            chk_pos(HOME_IDX);
            if (k < 2) begin
                tick(30);
                check(overcurrent_shutdown_a | overcurrent_shutdown_b,
                      1'b1);
                tick(20);
            end else begin
                bridge_output_on_low <= 1'b1;
                tick(2);
                bridge_output_on_low <= 1'b0;
                tick(2);
            end
            check(overcurrent_shutdown_a | overcurrent_shutdown_b,
                  1'b0);
        end
        stp(1'b1, 2'h1);
        overtemp_det <= 1'b1;
        tick(2);
        check(overtemperature_shutdown, 1'b1);
        fault_off();
        overtemp_det <= 1'b0;
        tick(3);
        check(overtemperature_shutdown, 1'b0);
        chk_pos(HOME_IDX);
        stp(1'b0, 2'h1);
        motor_supply_ok <= 1'b0;
        tick(2);
        check(low_supply_lockout, 1'b1);
        check(charge_pump_on, 1'b0);
        {motor_supply_ok, logic_supply_ok} <= 2'h2;
        tick(2);
        check(low_supply_lockout, 1'b1);
        logic_supply_ok <= 1'b1;
        tick(3);
        check(low_supply_lockout, 1'b0);
        check(charge_pump_on, 1'b1);
        chk_pos(HOME_IDX);
        close_out();
    end
endmodule
